// ---- verilog/clk_ratio_defs.vh ----
// Constants of the clock ratio control block: register offsets, field
// positions, reset values and timing counts.
// Assumes a single 125 MHz core clock and a plain strobe register port.
`ifndef CLK_RATIO_DEFS_VH
`define CLK_RATIO_DEFS_VH

// =============================================================
// Register offsets
`define OCR_OFFSET 8'h00
`define LBR_OFFSET 8'h04
`define UCR_OFFSET 8'h08
`define CFG_OFFSET 8'h0c
`define DRV_OFFSET 8'h10

// =============================================================
// Reset configuration word low fields and configuration register bits
`define RCW_FACTOR_LSB 0
`define RCW_FACTOR_MSB 3
`define RCW_CORE_LSB 4
`define RCW_CORE_MSB 10
`define RCW_MEM_MODE_BIT 11
`define RCW_LB_MODE_BIT 12
`define RCW_OSC_DIV_LSB 13
`define RCW_OSC_DIV_MSB 14
`define CFG_DIVPIN_BIT 15
`define CFG_HOST_BIT 16
`define CFG_RSVD_BIT 17
`define CFG_DONE_BIT 18

// =============================================================
// Derived ratio register fields
`define DRV_CSB_IN_LSB 0
`define DRV_CSB_SYNC_LSB 4
`define DRV_DDR_LSB 8
`define DRV_LBC_LSB 12
`define DRV_VCO_LSB 16

// =============================================================
// Reset values
`define OCR_RESET 8'h00
`define LBR_RESET 4'h8
`define UCR_UNIT_RESET 2'h1
`define HARD_RCW 32'h0000_2815

// =============================================================
// Timing counts
// Edges after release until the synchronised straps have settled.
`define CAPTURE_WAIT 3'h4

`endif

// ---- verilog/pin_sync3.v ----
// Three-stage pin synchroniser with agreement filter.
// Assumes the pins are asynchronous to the core clock.
`timescale 1ns/1ps

module pin_sync3 #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire i_core_clk,
    input wire i_arst_n,
    // Pins and result
    input wire [WIDTH-1:0] i_pin,
    output reg [WIDTH-1:0] o_level
);

    reg [WIDTH-1:0] s1_r;
    reg [WIDTH-1:0] s2_r;
    reg [WIDTH-1:0] s3_r;

    // A change is taken only when the second and third stages agree.
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s1_r <= {WIDTH{1'b0}};
            s2_r <= {WIDTH{1'b0}};
            s3_r <= {WIDTH{1'b0}};
            o_level <= {WIDTH{1'b0}};
        end else begin
            s1_r <= i_pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                o_level <= s3_r;
            end
        end
    end

endmodule

// ---- verilog/system_clock_ratio_control.v ----
// Clock source selection, sync and bus clock forwarding, and ratio
// derivation from the reset configuration word.
// Assumes clocks and straps arrive as pins sampled on the core clock,
// and that the board loops the sync output back to the sync input.
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "clk_ratio_defs.vh"

module system_clock_ratio_control #(
    parameter NUM_BUS_CLK = 5,
    parameter NUM_UNITS = 4,
    parameter CORE_W = 7
) (
    // Clock and reset
    input wire i_core_clk,
    input wire i_arst_n,
    // Clock and strap pins
    input wire i_host_primary_clock_in,
    input wire i_agent_clock_in,
    input wire i_sync_in,
    input wire i_input_divide_select_pin,
    input wire i_host_mode_pin,
    input wire i_hard_reset_sel,
    input wire [31:0] i_reset_config_word_low,
    // Register port
    input wire [7:0] i_reg_addr,
    input wire [31:0] i_reg_wr_data,
    input wire i_reg_wr,
    input wire i_reg_rd,
    output reg [31:0] o_reg_rd_data,
    // Forwarded clocks
    output reg o_sync_out,
    output reg [NUM_BUS_CLK-1:0] o_bus_clock_out_n,
    output reg o_memory_bus_clock_out,
    output reg o_memory_bus_clock_out_b,
    output reg [1:0] o_local_bus_clock_out,
    output reg [NUM_UNITS-1:0] o_unit_clock_enable,
    // Derived ratios
    output reg [3:0] o_csb_per_input,
    output reg [3:0] o_csb_per_sync,
    output reg [CORE_W-1:0] o_core_multiply_field,
    output reg [1:0] o_ddr_per_csb,
    output reg [1:0] o_lbc_per_csb,
    output reg [2:0] o_vco_per_csb,
    output reg o_config_reserved,
    output reg o_config_valid
);

    // =============================================================
    // Decoding shared by several places
    function unit_gate;
        input [1:0] code;
        input [1:0] phase;
        begin
            case (code)
                2'h0: unit_gate = 1'b0;
                2'h1: unit_gate = 1'b1;
                2'h2: unit_gate = ~phase[0];
                2'h3: unit_gate = (phase == 2'h0);
                default: unit_gate = 1'b0;
            endcase
        end
    endfunction

    function ratio_legal;
        input [3:0] ratio;
        begin
            ratio_legal = (ratio == 4'h2) || (ratio == 4'h4) || (ratio == 4'h8);
        end
    endfunction

    // =============================================================
    // Pin synchronisers
    wire [2:0] clk_lvl;
    wire [33:0] strap_lvl;

    pin_sync3 #(.WIDTH(3)) u_clk_sync (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_pin({i_sync_in, i_agent_clock_in, i_host_primary_clock_in}),
        .o_level(clk_lvl)
    );

    pin_sync3 #(.WIDTH(34)) u_strap_sync (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_pin({i_host_mode_pin, i_input_divide_select_pin, i_reset_config_word_low}),
        .o_level(strap_lvl)
    );

    wire hard_sel_lvl;

    pin_sync3 #(.WIDTH(1)) u_hard_sync (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_pin(i_hard_reset_sel),
        .o_level(hard_sel_lvl)
    );

    // =============================================================
    // Configuration capture, once per reset
    reg [2:0] wait_cnt_r;
    reg captured_r;
    reg [31:0] rcw_r;
    reg div_pin_r;
    reg host_r;
    wire [31:0] rcw_src = hard_sel_lvl ? `HARD_RCW : strap_lvl[31:0];

    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wait_cnt_r <= 3'h0;
            captured_r <= 1'b0;
            rcw_r <= 32'h0000_0000;
            div_pin_r <= 1'b0;
            host_r <= 1'b0;
        end else if (!captured_r) begin
            if (wait_cnt_r == `CAPTURE_WAIT) begin
                captured_r <= 1'b1;
                rcw_r <= rcw_src;
                div_pin_r <= strap_lvl[32];
                host_r <= strap_lvl[33];
            end else begin
                wait_cnt_r <= wait_cnt_r + 3'h1;
            end
        end
    end

    wire [3:0] factor_code = rcw_r[`RCW_FACTOR_MSB:`RCW_FACTOR_LSB];
    wire mem_mode = rcw_r[`RCW_MEM_MODE_BIT];
    wire lb_mode = rcw_r[`RCW_LB_MODE_BIT];
    wire [1:0] osc_div = rcw_r[`RCW_OSC_DIV_MSB:`RCW_OSC_DIV_LSB];
    wire factor_ok = (factor_code >= 4'h2) && (factor_code <= 4'h6);

    // =============================================================
    // Derived ratios, constant until the next reset
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_csb_per_input <= 4'h0;
            o_csb_per_sync <= 4'h0;
            o_core_multiply_field <= {CORE_W{1'b0}};
            o_ddr_per_csb <= 2'h0;
            o_lbc_per_csb <= 2'h0;
            o_vco_per_csb <= 3'h0;
            o_config_reserved <= 1'b0;
            o_config_valid <= 1'b0;
        end else begin
            o_config_valid <= captured_r && factor_ok;
            o_config_reserved <= captured_r && !factor_ok;
            o_core_multiply_field <= rcw_r[`RCW_CORE_LSB+CORE_W-1:`RCW_CORE_LSB];
            if (captured_r && factor_ok) begin
                o_csb_per_input <= factor_code;
                o_csb_per_sync <= div_pin_r ? factor_code : {factor_code[2:0], 1'b0};
                o_ddr_per_csb <= mem_mode ? 2'h2 : 2'h1;
                o_lbc_per_csb <= lb_mode ? 2'h2 : 2'h1;
                if (mem_mode || lb_mode) begin
                    o_vco_per_csb <= {osc_div, 1'b0};
                end else begin
                    o_vco_per_csb <= {1'b0, osc_div};
                end
            end else begin
                o_csb_per_input <= 4'h0;
                o_csb_per_sync <= 4'h0;
                o_ddr_per_csb <= 2'h0;
                o_lbc_per_csb <= 2'h0;
                o_vco_per_csb <= 3'h0;
            end
        end
    end

    // =============================================================
    // Software registers
    reg [NUM_BUS_CLK-1:0] output_clock_control_reg_r;
    reg [3:0] local_bus_clock_ratio_reg_r;
    reg [2*NUM_UNITS-1:0] unit_ratio_r;
    wire [31:0] cfg_word = {13'h0, captured_r, o_config_reserved, host_r, div_pin_r,
                            rcw_r[14:0]};
    wire [31:0] drv_word = {13'h0, o_vco_per_csb, 2'h0, o_lbc_per_csb, 2'h0,
                            o_ddr_per_csb, o_csb_per_sync, o_csb_per_input};

    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            output_clock_control_reg_r <= {NUM_BUS_CLK{1'b0}};
            local_bus_clock_ratio_reg_r <= `LBR_RESET;
            unit_ratio_r <= {NUM_UNITS{`UCR_UNIT_RESET}};
        end else if (i_reg_wr) begin
            case (i_reg_addr)
                `OCR_OFFSET: begin
                    output_clock_control_reg_r <= i_reg_wr_data[NUM_BUS_CLK-1:0];
                end
                `LBR_OFFSET: begin
                    if (ratio_legal(i_reg_wr_data[3:0])) begin
                        local_bus_clock_ratio_reg_r <= i_reg_wr_data[3:0];
                    end
                end
                `UCR_OFFSET: begin
                    unit_ratio_r <= i_reg_wr_data[2*NUM_UNITS-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Read data stand for exactly one cycle after the strobe.
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_reg_rd_data <= 32'h0000_0000;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                `OCR_OFFSET: o_reg_rd_data <= {{(32-NUM_BUS_CLK){1'b0}},
                                               output_clock_control_reg_r};
                `LBR_OFFSET: o_reg_rd_data <= {28'h0, local_bus_clock_ratio_reg_r};
                `UCR_OFFSET: o_reg_rd_data <= {{(32-2*NUM_UNITS){1'b0}}, unit_ratio_r};
                `CFG_OFFSET: o_reg_rd_data <= cfg_word;
                `DRV_OFFSET: o_reg_rd_data <= drv_word;
                default: o_reg_rd_data <= 32'h0000_0000;
            endcase
        end else begin
            o_reg_rd_data <= 32'h0000_0000;
        end
    end

    // =============================================================
    // Primary clock selection, halver and sync output
    wire primary_lvl = host_r ? clk_lvl[0] : clk_lvl[1];
    reg primary_d_r;
    reg half_r;
    reg sync_in_d_r;

    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            primary_d_r <= 1'b0;
            half_r <= 1'b0;
            o_sync_out <= 1'b0;
        end else begin
            primary_d_r <= primary_lvl;
            if (captured_r && primary_lvl && !primary_d_r) begin
                half_r <= ~half_r;
            end
            // Divide pin high forwards the clock whole, low forwards half.
            o_sync_out <= captured_r && (div_pin_r ? primary_lvl : half_r);
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_BUS_CLK; gi = gi + 1) begin : g_bus_clk
            always @(posedge i_core_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    o_bus_clock_out_n[gi] <= 1'b0;
                end else begin
                    o_bus_clock_out_n[gi] <= output_clock_control_reg_r[gi] &&
                                             captured_r &&
                                             (div_pin_r ? primary_lvl : half_r);
                end
            end
        end
    endgenerate

    // =============================================================
    // Memory and local bus clock dividers, driven from the core clock
    reg [3:0] lb_cnt_r;
    reg [1:0] unit_phase_r;

    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync_in_d_r <= 1'b0;
            o_memory_bus_clock_out <= 1'b0;
            o_memory_bus_clock_out_b <= 1'b1;
            o_local_bus_clock_out <= 2'h0;
            lb_cnt_r <= 4'h0;
            unit_phase_r <= 2'h0;
        end else begin
            sync_in_d_r <= clk_lvl[2];
            unit_phase_r <= unit_phase_r + 2'h1;
            if (o_config_valid) begin
                // The memory pair toggles every cycle: half the internal rate.
                o_memory_bus_clock_out <= ~o_memory_bus_clock_out;
                o_memory_bus_clock_out_b <= o_memory_bus_clock_out;
                if (lb_cnt_r >= (local_bus_clock_ratio_reg_r >> 1) - 4'h1) begin
                    lb_cnt_r <= 4'h0;
                    o_local_bus_clock_out <= ~o_local_bus_clock_out;
                end else begin
                    lb_cnt_r <= lb_cnt_r + 4'h1;
                end
            end
        end
    end

    generate
        for (gi = 0; gi < NUM_UNITS; gi = gi + 1) begin : g_unit
            always @(posedge i_core_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    o_unit_clock_enable[gi] <= 1'b0;
                end else begin
                    o_unit_clock_enable[gi] <= o_config_valid &&
                        unit_gate(unit_ratio_r[2*gi+1:2*gi], unit_phase_r);
                end
            end
        end
    endgenerate

endmodule

// ---- sim/clk_ratio_props.sv ----
// Checker for the clock ratio control block, watching only its top ports.
// Assumes the strap pins stay still from reset until the next reset.
`timescale 1ns/1ps
`include "clk_ratio_defs.vh"

module clk_ratio_props #(
    parameter NUM_BUS_CLK = 5,
    parameter NUM_UNITS = 4,
    parameter CORE_W = 7
) (
    // Clock, reset and straps
    input wire i_core_clk,
    input wire i_arst_n,
    input wire i_input_divide_select_pin,
    input wire i_hard_reset_sel,
    input wire [31:0] i_reset_config_word_low,
    // Register port
    input wire i_reg_rd,
    input wire [31:0] o_reg_rd_data,
    // Clocks and ratios
    input wire o_sync_out,
    input wire [NUM_BUS_CLK-1:0] o_bus_clock_out_n,
    input wire o_memory_bus_clock_out,
    input wire o_memory_bus_clock_out_b,
    input wire [3:0] o_csb_per_input,
    input wire [3:0] o_csb_per_sync,
    input wire [1:0] o_ddr_per_csb,
    input wire [1:0] o_lbc_per_csb,
    input wire [2:0] o_vco_per_csb,
    input wire o_config_reserved,
    input wire o_config_valid
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    // =========================================================
    // Effective configuration word.
    wire [31:0] w = i_hard_reset_sel ? `HARD_RCW : i_reset_config_word_low;
    sequence s_held;
        o_config_valid [*3];
    endsequence
    a_ratio_held: assert property (s_held |-> $stable(o_csb_per_input) && $stable(o_vco_per_csb))
        else $error("ratios changed while configured");
    a_mem_toggle: assert property (s_held |-> o_memory_bus_clock_out != $past(o_memory_bus_clock_out))
        else $error("memory clock did not toggle");
    sequence s_on;
        o_config_valid [*2];
    endsequence
    a_mem_pair: assert property (s_on |-> o_memory_bus_clock_out_b == $past(o_memory_bus_clock_out))
        else $error("memory clock complement wrong");
    a_factor_legal: assert property (o_config_valid |-> o_csb_per_input == w[3:0] && w[3:0] inside {[2:6]})
        else $error("input ratio wrong");
    a_sync_ratio: assert property (o_config_valid |-> o_csb_per_sync == (i_input_divide_select_pin ? w[3:0] : {w[2:0], 1'b0}))
        else $error("sync ratio wrong");
    a_mode_ratio: assert property (o_config_valid |-> o_ddr_per_csb == 2'd1 + w[11] && o_lbc_per_csb == 2'd1 + w[12])
        else $error("mode ratios wrong");
    a_vco_rule: assert property (o_config_valid |-> o_vco_per_csb == ((w[11] | w[12]) ? {w[14:13], 1'b0} : {1'b0, w[14:13]}))
        else $error("oscillator ratio wrong");
    a_reserved_flag: assert property (o_config_reserved |-> !o_config_valid && o_csb_per_input == 4'h0)
        else $error("reserved factor accepted");
    a_bus_follow: assert property (|o_bus_clock_out_n |-> o_sync_out || $past(o_sync_out))
        else $error("bus clock high without sync");
    a_rd_pulse: assert property (o_reg_rd_data != 32'h0 |-> $past(i_reg_rd))
        else $error("read data without read");
endmodule

// ---- sim/clk_source_model.sv ----
// Board model: oscillator, agent clock and the sync loop-back.
// Assumes pin clocks far slower than the core clock.
`timescale 1ns/1ps

module clk_source_model (
    // Mode and loop-back
    input wire i_host,
    input wire i_sync_out,
    // Pins
    output logic o_host_clk,
    output logic o_agent_clk,
    output wire o_sync_in
);
    initial begin
        o_host_clk = 1'b0;
        o_agent_clk = 1'b0;
    end
    // Agent boards hold the host clock pin low.
    always #32 o_host_clk = i_host ? ~o_host_clk : 1'b0;
    always #48 o_agent_clk = ~o_agent_clk;
    assign #2 o_sync_in = i_sync_out;
endmodule

// ---- sim/test_system_clock_ratio_control.sv ----
// Self-checking bench for the clock ratio control block.
// Assumes the board model loops the sync output back.
`timescale 1ns/1ps
`include "clk_ratio_defs.vh"

module test_system_clock_ratio_control;
    logic i_core_clk = 0, i_arst_n = 0, divp = 0, hostm = 1, hsel = 0, wr = 0, rd = 0;
    logic [31:0] cfg = 0, wd = 0, d, w, e, c0c;
    logic [7:0] ra = 0;
    wire [31:0] rdata;
    wire sync_o, sync_i, hclk, aclk, memory_bus_clock_out, resv, valid;
    wire [4:0] bus;
    wire [1:0] local_bus_clock_out, ddr, lbc;
    wire [3:0] uen, cpi, cps;
    wire [6:0] core;
    wire [2:0] vco;
    int n_mismatch = 0, n_tests = 0, rs, rl, rm, k, rb[5], hu[4], ft[10];
    always #4 i_core_clk = ~i_core_clk;
    system_clock_ratio_control system_clock_ratio_control_inst (.i_core_clk, .i_arst_n,
        .i_host_primary_clock_in(hclk), .i_agent_clock_in(aclk), .i_sync_in(sync_i),
        .i_input_divide_select_pin(divp), .i_host_mode_pin(hostm), .i_hard_reset_sel(hsel),
        .i_reset_config_word_low(cfg), .i_reg_addr(ra), .i_reg_wr_data(wd), .i_reg_wr(wr),
        .i_reg_rd(rd), .o_reg_rd_data(rdata), .o_sync_out(sync_o), .o_bus_clock_out_n(bus),
        .o_memory_bus_clock_out(memory_bus_clock_out), .o_memory_bus_clock_out_b(), .o_local_bus_clock_out(local_bus_clock_out),
        .o_unit_clock_enable(uen), .o_csb_per_input(cpi), .o_csb_per_sync(cps),
        .o_core_multiply_field(core), .o_ddr_per_csb(ddr), .o_lbc_per_csb(lbc),
        .o_vco_per_csb(vco), .o_config_reserved(resv), .o_config_valid(valid));
    clk_source_model clk_source_model_inst (.i_host(hostm), .i_sync_out(sync_o),
        .o_host_clk(hclk), .o_agent_clk(aclk), .o_sync_in(sync_i));
    // =========================================================
    // Compare, bus and measurement tasks.
    task conclude;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            n_mismatch++;
            $display("MISMATCH %0t value %h expected %h", $time, g, x);
        end
    endtask
    task chkn(input int g, input int x);
        n_tests++;
        if (g < x - 1 || g > x + 1) begin
            n_mismatch++;
            $display("MISMATCH %0t count %0d expected %0d", $time, g, x);
        end
    endtask
    task wreg(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_core_clk);
        wr <= 1;
        ra <= a;
        wd <= v;
        @(posedge i_core_clk);
        wr <= 0;
    endtask
    task rreg(input logic [7:0] a);
        @(posedge i_core_clk);
        rd <= 1;
        ra <= a;
        @(posedge i_core_clk);
        rd <= 0;
        #1 d = rdata;
    endtask
    function logic [31:0] drv(input logic [31:0] x, input logic dv);
        drv = 32'h0;
        drv[3:0] = x[3:0];
        drv[7:4] = dv ? x[3:0] : {x[2:0], 1'b0};
        drv[9:8] = 2'd1 + x[11];
        drv[13:12] = 2'd1 + x[12];
        drv[18:16] = (x[11] | x[12]) ? {x[14:13], 1'b0} : {1'b0, x[14:13]};
    endfunction
    task cfgr(input logic [3:0] f, input logic dv, input logic hm, input logic hs);
        logic lg;
        // No gigabit traffic runs here, so any bus and core rate pair is allowed.
        w = $urandom;
        w[3:0] = f;
        if (w[14:13] == 2'h0) w[13] = 1'b1;
        @(posedge i_core_clk);
        i_arst_n <= 0;
        cfg <= w;
        divp <= dv;
        hostm <= hm;
        hsel <= hs;
        repeat (6) @(posedge i_core_clk);
        i_arst_n <= 1;
        for (k = 0; k < 30 && valid !== 1'b1 && resv !== 1'b1; k++) @(posedge i_core_clk);
        if (k == 30) begin
            n_mismatch++;
            conclude;
        end
        #1;
        if (hs) w = `HARD_RCW;
        lg = w[3:0] inside {[2:6]};
        e = drv(w, dv);
        c0c = {13'h0, 1'b1, ~lg, hm, dv, w[14:0]};
        chk({valid, resv}, {lg, ~lg});
        if (lg) begin
            chk({13'h0, vco, 2'h0, lbc, 2'h0, ddr, cps, cpi}, e);
            chk(core, w[10:4]);
            rreg(8'h10);
            chk(d, e);
            rreg(8'h0c);
            chk(d, c0c);
        end
    endtask
    task meas;
        logic [11:0] p, c;
        rs = 0; rl = 0; rm = 0; p = 0;
        rb = '{0, 0, 0, 0, 0};
        hu = '{0, 0, 0, 0};
        repeat (192) begin
            @(posedge i_core_clk);
            #1 c = {uen, memory_bus_clock_out, local_bus_clock_out[0], bus, sync_o};
            rs += c[0] & ~p[0];
            for (k = 0; k < 5; k++) rb[k] += c[k+1] & ~p[k+1];
            rl += c[6] & ~p[6];
            rm += c[7] & ~p[7];
            for (k = 0; k < 4; k++) hu[k] += c[8+k];
            p = c;
        end
    endtask
    // =========================================================
    // Main sequence.
    initial begin
        logic [31:0] m;
        void'($urandom(32'h089e2da9));
        ft = '{2, 3, 4, 5, 6, 7, 0, 15, 1, 4};
        for (int i = 0; i < 10; i++) cfgr(ft[i], i % 2, 1'b1, i == 9);
        cfgr(4'h5, 1'b1, 1'b1, 1'b0);
        rreg(8'h00);
        chk(d, 32'h0);
        rreg(8'h04);
        chk(d, 32'h8);
        rreg(8'h08);
        chk(d, 32'h55);
        rreg(8'h14);
        chk(d, 32'h0);
        wreg(8'h0c, 32'hffffffff);
        wreg(8'h04, 32'h3);
        rreg(8'h0c);
        chk(d, c0c);
        rreg(8'h04);
        chk(d, 32'h8);
        wreg(8'h08, 32'he4);
        for (int i = 0; i < 3; i++) begin
            m = $urandom % 32;
            wreg(8'h00, m);
            wreg(8'h04, 32'h2 << i);
            meas;
            chkn(rs, 24);
            for (int j = 0; j < 5; j++) chkn(rb[j], m[j] ? rs : 0);
            chkn(rl, 192 / (2 << i));
            chkn(rm, 96);
            chkn(hu[0], 0);
            chkn(hu[1], 192);
            chkn(hu[2], 96);
            chkn(hu[3], 48);
        end
        cfgr(4'h4, 1'b0, 1'b1, 1'b0);
        meas;
        chkn(rs, 12);
        cfgr(4'h3, 1'b1, 1'b0, 1'b0);
        meas;
        chkn(rs, 16);
        cfgr(4'h2, 1'b0, 1'b0, 1'b0);
        meas;
        chkn(rs, 8);
        conclude;
    end
    initial begin
        #400000;
        n_mismatch++;
        conclude;
    end
endmodule

bind system_clock_ratio_control clk_ratio_props #(.NUM_BUS_CLK(NUM_BUS_CLK),
    .NUM_UNITS(NUM_UNITS), .CORE_W(CORE_W)) clk_ratio_props_inst (.i_core_clk, .i_arst_n,
    .i_input_divide_select_pin, .i_hard_reset_sel, .i_reset_config_word_low, .i_reg_rd,
    .o_reg_rd_data, .o_sync_out, .o_bus_clock_out_n, .o_memory_bus_clock_out,
    .o_memory_bus_clock_out_b, .o_csb_per_input, .o_csb_per_sync, .o_ddr_per_csb,
    .o_lbc_per_csb, .o_vco_per_csb, .o_config_reserved, .o_config_valid);
